// *** tb/flash_reset_and_resume_ctrl_tb_top.sv ***
// self-checking bench for the flash reset and resume control
`timescale 1ns/1ps
module flash_reset_and_resume_ctrl_tb_top
  import rst_resume_pkg::*;
;
  localparam int PU = 100;
  logic clk_sys_i, reset_i, reset_pin_n_i, select_n_i, data_line_0_i, cmd_valid_i;
  logic start_program_i, start_erase_i, start_integ_i, op_done_i, config_match_i;
  logic [7:0] cmd_code_i, status1_volatile_o, status2_volatile_o;
  logic device_ready_o, outputs_enable_o, reload_volatile_o, abort_ops_o, cmd_accept_o;
  int n_mismatch = 0, checked = 0, n_abort = 0, run = 0, n = 0, n0 = 0;
  int sus[4];
  logic [31:0] lfsr = 32'hc523;
  int dk[8] = '{2, 0, 1, 4, 2, 0, 4, 0};
  logic [7:0] dc[8] = '{0, CMD_SUSPEND, 0, 0, 0, CMD_RESUME, 0, CMD_RESUME};
  // 4 ns clock
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  flash_reset_and_resume_ctrl #(.POWER_UP_CYCLES(PU)) dut_u (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reset_pin_n_i(reset_pin_n_i),
    .select_n_i(select_n_i), .data_line_0_i(data_line_0_i), .cmd_valid_i(cmd_valid_i),
    .cmd_code_i(cmd_code_i), .start_program_i(start_program_i),
    .start_erase_i(start_erase_i), .start_integ_i(start_integ_i), .op_done_i(op_done_i),
    .config_match_i(config_match_i), .status1_volatile_o(status1_volatile_o),
    .status2_volatile_o(status2_volatile_o), .device_ready_o(device_ready_o),
    .outputs_enable_o(outputs_enable_o), .reload_volatile_o(reload_volatile_o),
    .abort_ops_o(abort_ops_o), .cmd_accept_o(cmd_accept_o));
  host_pin_model host_u (.clk_sys_i(clk_sys_i), .reset_pin_n_o(reset_pin_n_i),
    .select_n_o(select_n_i), .data_line_0_o(data_line_0_i));
  // abort pulses seen at the device's own edge
  always @(posedge clk_sys_i) if (abort_ops_o === 1'b1) n_abort++;
  function automatic logic [31:0] next_rand(input logic [31:0] l);
    return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
  endfunction : next_rand
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (exp !== got) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // one engine pulse or command, mirrored in the model
  task automatic act(input int k, input logic [7:0] code);
    @(negedge clk_sys_i);
    cmd_valid_i = (k == 0);
    cmd_code_i = code;
    start_program_i = (k == 1);
    start_erase_i = (k == 2);
    start_integ_i = (k == 3);
    op_done_i = (k == 4);
    if (k == 0 && code == CMD_SUSPEND && run != 0) begin
      sus[run] = 1;
      run = 0;
    end
    // program first, then erase, then integrity check
    if (k == 0 && code == CMD_RESUME)
      for (int o = 1; o < 4; o++) if (run == 0 && sus[o] == 1) begin
        run = o;
        sus[o] = 0;
      end
    // a new erase is refused while anything is suspended
    if (k > 0 && k < 4 && run == 0 && !(k == 2 && sus[1] + sus[2] + sus[3] > 0)) run = k;
    if (k == 4) run = 0;
    @(negedge clk_sys_i);
    {cmd_valid_i, start_program_i, start_erase_i, start_integ_i, op_done_i} = '0;
  endtask : act
  // status shows up two cycles after the cause, three after an engine start
  task automatic cmp();
    repeat (3) @(negedge clk_sys_i);
    check("busy", 8'(run != 0), 8'(status1_volatile_o[BUSY_BIT]));
    check("erase_susp", 8'(sus[2]), 8'(status2_volatile_o[ERASE_SUSP_BIT]));
    check("integ_susp", 8'(sus[3]), 8'(status2_volatile_o[INTEG_SUSP_BIT]));
  endtask : cmp
  // bounded wait for ready, counting falling edges
  task automatic wait_ready(input int lim, output int cnt);
    cnt = 0;
    while (device_ready_o !== 1'b1 && cnt < lim) begin
      @(negedge clk_sys_i);
      cnt++;
    end
    if (cnt >= lim) begin
      n_mismatch++;
      $display("FAIL ready expected 1 seen timeout");
      report_and_stop();
    end
  endtask : wait_ready
  initial begin
    reset_i = 1'b1;
    {cmd_valid_i, start_program_i, start_erase_i, start_integ_i, op_done_i} = '0;
    cmd_code_i = 8'h00;
    config_match_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    reset_i = 1'b0;
    // a long pin pulse inside power-up must not stretch it
    fork
      host_u.pin_reset(60);
    join_none
    wait_ready(400, n);
    check("power_up", 8'h01, 8'(n >= PU && n <= PU + 6));
    foreach (dk[i]) begin
      act(dk[i], dc[i]);
      cmp();
    end
    act(3, 8'h00);
    act(0, CMD_SUSPEND);
    act(0, CMD_RESUME);
    act(0, CMD_SUSPEND);
    cmp();
    // random walk; new starts only with nothing suspended
    repeat (30) begin
      lfsr = next_rand(lfsr);
      if (lfsr[0]) act(0, lfsr[1] ? CMD_SUSPEND : CMD_RESUME);
      else if (run != 0) act(4, 8'h00);
      else if (sus[1] + sus[2] + sus[3] == 0) act(1 + int'(lfsr[3:2]) % 3, 8'h00);
      cmp();
    end
    config_match_i = lfsr[5];
    n0 = n_abort;
    act(0, CMD_SOFT_RESET_ENABLE);
    act(0, lfsr[4] ? CMD_READ_STATUS1 : CMD_READ_ANY_REG);
    act(0, CMD_SOFT_RESET);
    cmp();
    check("no_abort", 8'(n0), 8'(n_abort));
    act(0, CMD_SOFT_RESET_ENABLE);
    act(0, CMD_SOFT_RESET);
    repeat (3) @(negedge clk_sys_i);
    check("soft_abort", 8'(n0 + 1), 8'(n_abort));
    check("soft_oe", 8'(config_match_i), 8'(outputs_enable_o));
    wait_ready(400, n);
    check("soft_len", 8'h01, 8'(n >= 238 && n <= 252));
    run = 0;
    sus = '{default: 0};
    cmp();
    act(3, 8'h00);
    host_u.pin_reset(60);
    check("hw_abort", 8'(n0 + 2), 8'(n_abort));
    check("hw_oe", 8'h00, 8'(outputs_enable_o));
    wait_ready(200, n);
    check("hw_len", 8'h01, 8'(n <= RESET_RECOVERY_CYC + 8));
    run = 0;
    cmp();
    act(1, 8'h00);
    act(0, CMD_SUSPEND);
    host_u.signal_reset(4 + int'(lfsr[2:0]));
    // the reset fires a few cycles after the last synced rise
    repeat (8) @(negedge clk_sys_i);
    check("sig_abort", 8'(n0 + 3), 8'(n_abort));
    check("sig_oe", 8'h00, 8'(outputs_enable_o));
    wait_ready(200, n);
    check("sig_len", 8'h01, 8'(n <= SIGNALING_RESET_CYC + 8));
    sus = '{default: 0};
    cmp();
    report_and_stop();
  end
endmodule : flash_reset_and_resume_ctrl_tb_top

// *** tb/host_pin_model.sv ***
// host-side model driving the reset pin, select and data line 0
`timescale 1ns/1ps
module host_pin_model (
  // clock
  input wire logic clk_sys_i,
  // pins towards the device
  output logic reset_pin_n_o,
  output logic select_n_o,
  output logic data_line_0_o
);
  logic drive_q = 1'b0;
  logic frame_d0_q = 1'b0;
  logic idle_d0_q = 1'b0;
  // select rises with supply and stays high through power-up
  initial begin
    reset_pin_n_o = 1'b1;
    select_n_o = 1'b1;
  end
  // undriven line has no pull, so show a level that moves every cycle
  always @(negedge clk_sys_i) idle_d0_q <= ~idle_d0_q;
  assign data_line_0_o = drive_q ? frame_d0_q : idle_d0_q;
  // reset pin low for a number of cycles
  task automatic pin_reset(input int cycles);
    @(negedge clk_sys_i);
    reset_pin_n_o = 1'b0;
    repeat (cycles) @(negedge clk_sys_i);
    reset_pin_n_o = 1'b1;
  endtask : pin_reset
  // four select pulses, data held past each rise, starting low
  task automatic signal_reset(input int width);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_sys_i);
      drive_q = 1'b1;
      frame_d0_q = i[0];
      select_n_o = 1'b0;
      repeat (width) @(negedge clk_sys_i);
      select_n_o = 1'b1;
      repeat (width) @(negedge clk_sys_i);
      drive_q = 1'b0;
    end
  endtask : signal_reset
endmodule : host_pin_model

// *** tb/rst_resume_checker.sv ***
// port-level assertions for the reset and resume control
`timescale 1ns/1ps
module rst_resume_checker
  import rst_resume_pkg::*;
#(
  parameter int POWER_UP_CYCLES = 20
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // watched ports
  input wire logic reset_pin_n_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [7:0] status1_volatile_o,
  input wire logic [7:0] status2_volatile_o,
  input wire logic device_ready_o,
  input wire logic outputs_enable_o,
  input wire logic reload_volatile_o,
  input wire logic abort_ops_o,
  input wire logic cmd_accept_o
);
  logic en_q;
  logic por_q;
  logic [7:0] low_q;
  logic [31:0] cnt_q;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  // enable lives only until the next accepted command or any reset
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) en_q <= 1'b0;
    else if (cmd_accept_o) en_q <= (cmd_code_i == CMD_SOFT_RESET_ENABLE);
    else if (!device_ready_o) en_q <= 1'b0;
  end
  // power-on window, closed by the first ready
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) por_q <= 1'b1;
    else if (device_ready_o) por_q <= 1'b0;
  end
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) cnt_q <= '0;
    else if (por_q) cnt_q <= cnt_q + 32'h1;
  end
  // saturating length of the pin's low phase
  always_ff @(posedge clk_sys_i) begin
    if (reset_pin_n_i) low_q <= '0;
    else if (low_q != 8'hff) low_q <= low_q + 8'h1;
  end
  accept_needs_ready_a: assert property (
    cmd_accept_o |-> cmd_valid_i && device_ready_o) else $error("accept outside ready");
  por_length_a: assert property (
    por_q && device_ready_o |-> cnt_q >= POWER_UP_CYCLES && cnt_q <= POWER_UP_CYCLES + 6)
    else $error("power-up wait out of range");
  hw_recovery_a: assert property (
    $rose(reset_pin_n_i) && !por_q |-> ##[1:125] device_ready_o) else $error("slow recovery");
  long_pulse_a: assert property (
    low_q == 8'd58 && !por_q |-> !device_ready_o && !outputs_enable_o)
    else $error("long pin pulse not resetting");
  abort_reload_a: assert property (
    abort_ops_o |-> reload_volatile_o ##1 !abort_ops_o) else $error("abort pulse malformed");
  abort_blocks_a: assert property (
    abort_ops_o |=> !device_ready_o [*8]) else $error("ready during reset");
  soft_fire_a: assert property (
    cmd_accept_o && cmd_code_i == CMD_SOFT_RESET && en_q |-> ##[1:3] abort_ops_o)
    else $error("soft reset not started");
  soft_blocked_a: assert property (
    cmd_accept_o && cmd_code_i == CMD_SOFT_RESET && !en_q |=> !abort_ops_o [*4])
    else $error("soft reset without enable");
  resume_busy_a: assert property (
    cmd_accept_o && cmd_code_i == CMD_RESUME
    && (status2_volatile_o[ERASE_SUSP_BIT] || status2_volatile_o[INTEG_SUSP_BIT])
    |-> ##2 status1_volatile_o[BUSY_BIT]) else $error("resume left busy clear");
  cover property (abort_ops_o && !reset_pin_n_i);
  cover property (cmd_accept_o && cmd_code_i == CMD_RESUME);
  cover property (cmd_accept_o && cmd_code_i == CMD_SOFT_RESET && en_q);
endmodule : rst_resume_checker

bind flash_reset_and_resume_ctrl rst_resume_checker #(
  .POWER_UP_CYCLES(POWER_UP_CYCLES)
) chk_u (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reset_pin_n_i(reset_pin_n_i),
  .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
  .status1_volatile_o(status1_volatile_o), .status2_volatile_o(status2_volatile_o),
  .device_ready_o(device_ready_o), .outputs_enable_o(outputs_enable_o),
  .reload_volatile_o(reload_volatile_o), .abort_ops_o(abort_ops_o),
  .cmd_accept_o(cmd_accept_o)
);

// *** verilog/cycle_timer.sv ***
// loadable down counter that flags when a wait has run out
`timescale 1ns/1ps
module cycle_timer #(
  parameter int WIDTH = 20
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // control
  input wire logic load_i,
  input wire logic [WIDTH-1:0] count_i,
  // status
  output logic done_o
);
  logic [WIDTH-1:0] cnt_q;

  // refuse widths the counter cannot serve
  if (WIDTH < 2) begin : g_bad_width
    $error("cycle_timer: WIDTH too small");
  end

  // reload wins over reset and counting, so a wait loaded in reset starts on release
  always_ff @(posedge clk_sys_i) begin
    if (load_i) begin
      cnt_q <= count_i;
    end else if (reset_i) begin
      cnt_q <= '0;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign done_o = (cnt_q == '0) && !load_i;
endmodule : cycle_timer

// *** verilog/flash_reset_and_resume_ctrl.sv ***
// reset sequencing and suspend/resume control of the flash device
`timescale 1ns/1ps
module flash_reset_and_resume_ctrl
  import rst_resume_pkg::*;
#(
  parameter int POWER_UP_CYCLES = POWER_UP_CYC,
  parameter int TIMER_WIDTH = 20
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // pins from the host
  input wire logic reset_pin_n_i,
  input wire logic select_n_i,
  input wire logic data_line_0_i,
  // decoded command, one pulse at select rise
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_code_i,
  // embedded engine
  input wire logic start_program_i,
  input wire logic start_erase_i,
  input wire logic start_integ_i,
  input wire logic op_done_i,
  input wire logic config_match_i,
  // status and control outputs
  output logic [7:0] status1_volatile_o,
  output logic [7:0] status2_volatile_o,
  output logic device_ready_o,
  output logic outputs_enable_o,
  output logic reload_volatile_o,
  output logic abort_ops_o,
  output logic cmd_accept_o
);

  // refuse parameter values the shared timer cannot hold
  if (POWER_UP_CYCLES < 1) begin : g_bad_power_up
    $error("POWER_UP_CYCLES must be at least 1");
  end
  if (POWER_UP_CYCLES >= (1 << TIMER_WIDTH)) begin : g_bad_width
    $error("TIMER_WIDTH too small");
  end

  logic reset_pin_lvl;
  logic select_lvl;
  logic data0_lvl;
  logic select_lvl_q;
  logic select_rise;
  logic select_fall;
  logic timer_load;
  logic [TIMER_WIDTH-1:0] timer_count;
  logic timer_done;
  logic [TIMER_WIDTH-1:0] pulse_cnt_q;
  logic pulse_long;

  rst_state_t rst_q;
  op_state_t op_q;
  logic prog_susp_q;
  logic erase_susp_q;
  logic integ_susp_q;
  logic busy_q;
  logic soft_en_q;
  logic [2:0] sig_cnt_q;
  logic sig_dq_q;
  logic sig_dq_at_fall_q;
  logic sig_trigger;
  logic soft_trigger;
  logic hw_trigger;
  logic hw_entry;
  logic is_resume;
  logic is_suspend;

  // pins cross in from the host domain
  pin_sync #(.RESET_LEVEL(1'b1)) u_sync_rst (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .pin_i(reset_pin_n_i), .level_o(reset_pin_lvl)
  );
  pin_sync #(.RESET_LEVEL(1'b1)) u_sync_cs (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .pin_i(select_n_i), .level_o(select_lvl)
  );
  pin_sync #(.RESET_LEVEL(1'b0)) u_sync_data0 (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .pin_i(data_line_0_i), .level_o(data0_lvl)
  );

  // one timer serves every reset wait, since waits never overlap
  cycle_timer #(.WIDTH(TIMER_WIDTH)) u_timer (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .load_i(timer_load),
    .count_i(timer_count), .done_o(timer_done)
  );

  // select edge detection on the filtered level
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      select_lvl_q <= 1'b1;
    end else begin
      select_lvl_q <= select_lvl;
    end
  end
  assign select_rise = select_lvl && !select_lvl_q;
  assign select_fall = !select_lvl && select_lvl_q;

  // reset pin low time, saturating
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || reset_pin_lvl) begin
      pulse_cnt_q <= '0;
    end else if (!pulse_long) begin
      pulse_cnt_q <= pulse_cnt_q + 1'b1;
    end
  end
  assign pulse_long = pulse_cnt_q >= TIMER_WIDTH'(RESET_PULSE_MIN_CYC);

  // ignored entirely while power-on reset runs
  assign hw_trigger = pulse_long && (rst_q != RS_POR);
  // a held pin keeps the trigger up; only its first cycle starts a reset
  assign hw_entry = hw_trigger && (rst_q != RS_HW_HOLD);

  // signaling reset pattern: four select pulses, data line alternating;
  // cleared once it fires, else select staying high would retrigger forever
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || rst_q == RS_POR || sig_trigger) begin
      sig_cnt_q <= '0;
      sig_dq_q <= 1'b0;
      sig_dq_at_fall_q <= 1'b0;
    end else if (select_fall) begin
      sig_dq_at_fall_q <= data0_lvl;
    end else if (select_rise) begin
      // a pulse counts if data line held and alternated from the last
      if (data0_lvl == sig_dq_at_fall_q &&
          (sig_cnt_q == '0 || data0_lvl != sig_dq_q)) begin
        sig_cnt_q <= (sig_cnt_q == 3'(SIGNAL_PULSES)) ? 3'd1 : sig_cnt_q + 3'd1;
        sig_dq_q <= data0_lvl;
      end else begin
        sig_cnt_q <= 3'd1;
        sig_dq_q <= data0_lvl;
      end
      // a real command cycle breaks the pattern
    end else if (cmd_valid_i) begin
      sig_cnt_q <= '0;
    end
  end
  // any state other than power-on reset may be interrupted
  assign sig_trigger = (sig_cnt_q == 3'(SIGNAL_PULSES)) && select_lvl &&
                       !cmd_valid_i && rst_q != RS_POR;

  // commands are only taken when ready
  assign cmd_accept_o = cmd_valid_i && (rst_q == RS_READY);
  assign is_resume = cmd_accept_o && cmd_code_i == CMD_RESUME;
  assign is_suspend = cmd_accept_o && cmd_code_i == CMD_SUSPEND;

  // enable must be the very last command before the reset command
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || rst_q != RS_READY) begin
      soft_en_q <= 1'b0;
    end else if (cmd_accept_o) begin
      soft_en_q <= (cmd_code_i == CMD_SOFT_RESET_ENABLE);
    end
  end
  // reset pin level plays no part here
  assign soft_trigger = cmd_accept_o && cmd_code_i == CMD_SOFT_RESET && soft_en_q;

  // reset sequencer
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rst_q <= RS_POR;
    end else if (hw_trigger) begin
      rst_q <= RS_HW_HOLD;
    end else if (sig_trigger) begin
      rst_q <= RS_SIG_RESET;
    end else begin
      case (rst_q)
        RS_POR: if (timer_done) rst_q <= RS_READY;
        RS_HW_HOLD: if (reset_pin_lvl) rst_q <= RS_HW_RECOVER;
        RS_HW_RECOVER: if (timer_done) rst_q <= RS_READY;
        RS_SIG_RESET: if (timer_done) rst_q <= RS_READY;
        RS_SOFT_RESET: if (timer_done) rst_q <= RS_READY;
        RS_READY: if (soft_trigger) rst_q <= RS_SOFT_RESET;
        default: rst_q <= RS_POR;
      endcase
    end
  end

  // timer loads on entry to each timed state
  always_comb begin
    timer_load = 1'b0;
    timer_count = '0;
    if (reset_i) begin
      timer_load = 1'b1;
      timer_count = TIMER_WIDTH'(POWER_UP_CYCLES);
    end else if (hw_trigger) begin
      timer_load = 1'b0;
    end else if (sig_trigger) begin
      timer_load = 1'b1;
      timer_count = TIMER_WIDTH'(SIGNALING_RESET_CYC);
    end else if (rst_q == RS_HW_HOLD && reset_pin_lvl) begin
      timer_load = 1'b1;
      timer_count = TIMER_WIDTH'(RESET_RECOVERY_CYC);
    end else if (rst_q == RS_READY && soft_trigger) begin
      timer_load = 1'b1;
      timer_count = TIMER_WIDTH'(SOFT_RESET_CYC);
    end
  end

  // suspend and resume bookkeeping; any reset drops all operations
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || hw_trigger || sig_trigger || soft_trigger || rst_q != RS_READY) begin
      op_q <= OP_IDLE;
      prog_susp_q <= 1'b0;
      erase_susp_q <= 1'b0;
      integ_susp_q <= 1'b0;
    end else begin
      case (op_q)
        OP_IDLE: begin
          if (is_resume) begin
            if (prog_susp_q) begin
              op_q <= erase_susp_q ? OP_PROG_IN_ERASE_SUSP : OP_PROGRAM;
              prog_susp_q <= 1'b0;
            end else if (erase_susp_q) begin
              op_q <= OP_ERASE;
              erase_susp_q <= 1'b0;
            end else if (integ_susp_q) begin
              op_q <= OP_INTEG;
              integ_susp_q <= 1'b0;
            end
            // nothing suspended: command has no effect
          end else if (start_program_i) begin
            op_q <= erase_susp_q ? OP_PROG_IN_ERASE_SUSP : OP_PROGRAM;
          end else if (start_erase_i && !prog_susp_q && !erase_susp_q && !integ_susp_q) begin
            op_q <= OP_ERASE;
          end else if (start_integ_i) begin
            op_q <= OP_INTEG;
          end
        end
        OP_PROGRAM, OP_ERASE, OP_INTEG, OP_PROG_IN_ERASE_SUSP: begin
          // suspend always honoured, even right after a resume
          if (is_suspend) begin
            op_q <= OP_IDLE;
            prog_susp_q <= prog_susp_q || op_q == OP_PROGRAM || op_q == OP_PROG_IN_ERASE_SUSP;
            erase_susp_q <= erase_susp_q || op_q == OP_ERASE;
            integ_susp_q <= integ_susp_q || op_q == OP_INTEG;
          end else if (op_done_i) begin
            op_q <= OP_IDLE;
          end
        end
        default: op_q <= OP_IDLE;
      endcase
    end
  end

  // busy follows the engine; set on resume and held until done or suspend
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      busy_q <= 1'b1;
    end else if (rst_q != RS_READY || hw_trigger || sig_trigger || soft_trigger) begin
      busy_q <= 1'b1;
    end else if (is_resume && (prog_susp_q || erase_susp_q || integ_susp_q)) begin
      busy_q <= 1'b1;
    end else begin
      busy_q <= (op_q != OP_IDLE) && !is_suspend && !op_done_i;
    end
  end

  // status registers reload on every reset
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      status1_volatile_o <= STATUS_RESET_VALUE;
      status2_volatile_o <= STATUS_RESET_VALUE;
    end else begin
      status1_volatile_o <= STATUS_RESET_VALUE;
      status1_volatile_o[BUSY_BIT] <= busy_q;
      status2_volatile_o <= STATUS_RESET_VALUE;
      status2_volatile_o[ERASE_SUSP_BIT] <= erase_susp_q;
      status2_volatile_o[INTEG_SUSP_BIT] <= integ_susp_q;
    end
  end

  // outputs float in pin and signaling resets; soft reset allows status-1 reads only while config_match_i is set
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      outputs_enable_o <= 1'b0;
      device_ready_o <= 1'b0;
      reload_volatile_o <= 1'b0;
      abort_ops_o <= 1'b0;
    end else begin
      device_ready_o <= (rst_q == RS_READY);
      outputs_enable_o <= (rst_q == RS_READY) ||
                          (rst_q == RS_SOFT_RESET && config_match_i);
      reload_volatile_o <= soft_trigger || sig_trigger || hw_entry;
      abort_ops_o <= soft_trigger || sig_trigger || hw_entry;
    end
  end

endmodule : flash_reset_and_resume_ctrl

// *** verilog/pin_sync.sv ***
// three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // pin and filtered level
  input wire logic pin_i,
  output logic level_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // first stage only feeds the second
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      s1_q <= RESET_LEVEL;
      s2_q <= RESET_LEVEL;
      s3_q <= RESET_LEVEL;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // level changes only once stages two and three agree
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      level_o <= RESET_LEVEL;
    end else if (s2_q == s3_q) begin
      level_o <= s2_q;
    end
  end
endmodule : pin_sync

// *** verilog/rst_resume_pkg.sv ***
// shared constants and types for the flash reset and resume control
package rst_resume_pkg;

  // command opcodes as seen by this block (decoded upstream)
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_SOFT_RESET_ENABLE = 8'h66;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h99;
  localparam logic [7:0] CMD_READ_STATUS1 = 8'h05;
  localparam logic [7:0] CMD_READ_ANY_REG = 8'h65;

  // status bit positions
  localparam int BUSY_BIT = 0;
  localparam int ERASE_SUSP_BIT = 1;
  localparam int INTEG_SUSP_BIT = 4;
  localparam logic [7:0] STATUS_RESET_VALUE = 8'h00;

  // clock and times in ns
  localparam int CLK_PERIOD_NS = 4;
  localparam int POWER_UP_DELAY_NS = 300000;
  localparam int RESET_RECOVERY_NS = 450;
  localparam int RESET_PULSE_MIN_NS = 200;
  localparam int SIGNALING_RESET_NS = 450;
  localparam int SOFT_RESET_NS = 1000;

  // derived cycle counts: least times round up
  localparam int POWER_UP_CYC = (POWER_UP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_RECOVERY_CYC = RESET_RECOVERY_NS / CLK_PERIOD_NS;
  localparam int RESET_PULSE_MIN_CYC = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SIGNALING_RESET_CYC = SIGNALING_RESET_NS / CLK_PERIOD_NS;
  localparam int SOFT_RESET_CYC = SOFT_RESET_NS / CLK_PERIOD_NS;

  localparam int SIGNAL_PULSES = 4;

  // operation state of the embedded engine
  typedef enum logic [2:0] {
    OP_IDLE,
    OP_PROGRAM,
    OP_ERASE,
    OP_INTEG,
    OP_PROG_IN_ERASE_SUSP
  } op_state_t;

  // reset sequencer state
  typedef enum logic [2:0] {
    RS_POR,
    RS_HW_HOLD,
    RS_HW_RECOVER,
    RS_SIG_RESET,
    RS_SOFT_RESET,
    RS_READY
  } rst_state_t;

endpackage : rst_resume_pkg
